/* hdl/host_port_pkg.sv */
package host_port_pkg;
   // ****************************************
   // cpu-side register byte addresses
   // ****************************************
   localparam logic [31:0] ADDR_PORT_CONTROL = 32'h0188_0000;
   localparam logic [31:0] ADDR_PORT_WRITE_ADDRESS = 32'h0188_0004;
   localparam logic [31:0] ADDR_PORT_READ_ADDRESS = 32'h0188_0008;
   localparam logic [31:0] ADDR_TRANSFER_REQUEST_CONTROL = 32'h018a_0000;
   // ****************************************
   // reset values and fields
   // ****************************************
   localparam logic [31:0] RESET_PORT_CONTROL = 32'h0000_0000;
   localparam logic [31:0] RESET_ADDRESS = 32'h0000_0000;
   localparam logic [31:0] RESET_TRCTL = 32'h0000_0000;
   localparam int CTRL_HALFWORD_ORDER_BIT = 0;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;
   // ****************************************
   // target select codes
   // ****************************************
   localparam logic [1:0] SEL_CONTROL = 2'h0;
   localparam logic [1:0] SEL_DATA_INC = 2'h1;
   localparam logic [1:0] SEL_ADDRESS = 2'h2;
   localparam logic [1:0] SEL_DATA_FIXED = 2'h3;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLOCK_PERIOD_PS = 10000;
   localparam int WAIT_RISE_MAX_PS = 8000;
   localparam int WAIT_RISE_CYCLES = (WAIT_RISE_MAX_PS / CLOCK_PERIOD_PS) < 1 ? 1
                                      : (WAIT_RISE_MAX_PS / CLOCK_PERIOD_PS);
   localparam int WRITE_BUFFER_DEPTH = 4;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_HOLD = 2'b10
   } access_state_t;
endpackage : host_port_pkg

/* hdl/dma_req_if.sv */
`timescale 1ns/1ps
// ****************************************
// request path toward the dma address generator
// ****************************************
interface dma_req_if;
   logic rd_req;
   logic rd_done;
   logic [31:0] rd_addr;
   logic [31:0] rd_data;
   logic wr_push;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic wr_full;
   modport port (output rd_req, output rd_addr, input rd_done, input rd_data,
                 output wr_push, output wr_addr, output wr_data, input wr_full);
   modport engine (input rd_req, input rd_addr, output rd_done, output rd_data,
                   input wr_push, input wr_addr, input wr_data, output wr_full);
endinterface : dma_req_if

/* hdl/dma_write_buffer.sv */
`timescale 1ns/1ps
// ****************************************
// write buffer between host port and dma
// ****************************************
module dma_write_buffer
   import host_port_pkg::*;
#(
   parameter int DEPTH = WRITE_BUFFER_DEPTH
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // host port side
   dma_req_if.engine req,
   // dma side
   output logic out_valid,
   output logic [63:0] out_addr_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [63:0] mem [DEPTH];
   logic [AW:0] wp, rp, next_wp, next_rp;

   // pointer arithmetic
   always_comb begin
      next_wp = wp;
      next_rp = rp;
      if (req.wr_push && !req.wr_full) begin
         next_wp = wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         next_rp = rp + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wp <= '0;
         rp <= '0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
      end
   end

   always_ff @(posedge mclk) begin
      if (req.wr_push && !req.wr_full) begin
         mem[wp[AW-1:0]] <= {req.wr_addr, req.wr_data};
      end
   end

   // honest full and empty
   assign req.wr_full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
   assign out_valid = (wp != rp);
   assign out_addr_data = mem[rp[AW-1:0]];
endmodule : dma_write_buffer

/* hdl/host_access_port.sv */
`timescale 1ns/1ps
// How it works
// - host is master, reading and writing cpu memory and peripherals through this port.
// - every data access other than a narrow second-half read or first-half write (sent with its second half) is carried to memory by the dma request path.
// - control and address registers are reachable by host pins and cpu bus.
// - data register exists only on host pins, never at a cpu address.
// - host address write loads both write-address and read-address registers.
// - cpu reaches write-address and read-address registers separately at own offsets.
// - combined strobe is not(strobe_a xor strobe_b) or chip select.
// - data read start, except a narrow second-half read, issues dma fetch; wait stays high until data loads.
// - data write raises wait while write buffer full, drops when space frees.
// - narrow mode second half-word comes from held word, no new fetch.
// - data bus driven during read strobe, released when strobe rises.
// - wait rises within one cycle of strobe falling for data reads that need a fetch.
module host_access_port
   import host_port_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // host pins
   input wire logic port_chip_select_n,
   input wire logic data_strobe_a,
   input wire logic data_strobe_b,
   input wire logic address_latch_n,
   input wire logic [1:0] target_select,
   input wire logic read_write_select,
   input wire logic halfword_identifier,
   input wire logic narrow_halfword_mode,
   input wire logic [31:0] host_data_in,
   output logic [31:0] host_data_out,
   output logic host_data_oe_n,
   output logic wait_ready,
   // cpu configuration bus
   input wire logic cpu_sel,
   input wire logic cpu_write,
   input wire logic [31:0] cpu_addr,
   input wire logic [31:0] cpu_wdata,
   output logic [31:0] cpu_rdata,
   // dma read fetch
   output logic dma_rd_req,
   output logic [31:0] dma_rd_addr,
   input wire logic dma_rd_done,
   input wire logic [31:0] dma_rd_data,
   // dma write drain
   output logic dma_wr_valid,
   output logic [63:0] dma_wr_addr_data,
   input wire logic dma_wr_ready
);
   // ****************************************
   // reset release
   // ****************************************
   logic rst_meta, rst_n;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   dma_req_if req ();

   // ****************************************
   // strobe framing
   // ****************************************
   logic strobe_n, strobe_q, strobe_fall, strobe_rise;
   logic [1:0] sel_q;
   logic rw_q, hw_q;
   assign strobe_n = ~(data_strobe_a ^ data_strobe_b) | port_chip_select_n;
   assign strobe_fall = strobe_q & ~strobe_n;
   assign strobe_rise = ~strobe_q & strobe_n;

   // address latch captures qualifiers when used, and strobe fall captures them again in every case
   logic [1:0] next_sel_q;
   logic next_rw_q, next_hw_q;
   always_comb begin
      next_sel_q = sel_q;
      next_rw_q = rw_q;
      next_hw_q = hw_q;
      if (!address_latch_n || strobe_fall) begin
         next_sel_q = target_select;
         next_rw_q = read_write_select;
         next_hw_q = halfword_identifier;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   logic [31:0] port_control, port_write_address, port_read_address;
   logic [31:0] transfer_request_control, port_data;
   logic [31:0] next_ctrl, next_wa, next_ra, next_trctl, next_data;
   logic [31:0] wr_half_lo, next_wr_half_lo;
   access_state_t state, next_state;
   logic is_data, is_read, second_half, hw_first_low;
   logic [1:0] sel_eff;
   logic rw_eff, hw_eff;

   // qualifiers are valid at the fall even without the latch strobe
   assign sel_eff = !address_latch_n ? target_select : (strobe_fall ? target_select : sel_q);
   assign rw_eff = strobe_fall ? read_write_select : rw_q;
   assign hw_eff = strobe_fall ? halfword_identifier : hw_q;
   assign is_data = (sel_eff == SEL_DATA_INC) || (sel_eff == SEL_DATA_FIXED);
   assign is_read = rw_eff;
   assign hw_first_low = port_control[CTRL_HALFWORD_ORDER_BIT];
   // second half-word flagged by the identifier in narrow mode
   assign second_half = narrow_halfword_mode & hw_eff;
   // half lane: first half sits low when the order bit is set, second half opposite
   logic hw_upper;
   assign hw_upper = ~(hw_q ^ hw_first_low);

   function automatic logic [31:0] merge_half(input logic [31:0] old, input logic [15:0] h,
                                              input logic upper);
      merge_half = upper ? {h, old[15:0]} : {old[31:16], h};
   endfunction : merge_half

   // host access sequencing and cpu bus
   always_comb begin
      next_state = state;
      next_ctrl = port_control;
      next_wa = port_write_address;
      next_ra = port_read_address;
      next_trctl = transfer_request_control;
      next_data = port_data;
      next_wr_half_lo = wr_half_lo;
      req.rd_req = 1'b0;
      req.wr_push = 1'b0;
      req.wr_data = port_data;
      unique case (state)
         ST_IDLE: begin
            if (strobe_fall && is_data && is_read && !second_half) begin
               next_state = ST_FETCH;
            end else if (strobe_fall) begin
               next_state = ST_HOLD;
            end
         end
         ST_FETCH: begin
            req.rd_req = 1'b1;
            if (req.rd_done) begin
               next_data = req.rd_data;
               next_state = ST_HOLD;
               if (sel_q == SEL_DATA_INC) begin
                  next_ra = port_read_address + WORD_STEP;
               end
            end
         end
         ST_HOLD: begin
            // writes complete at strobe rise, after wait has dropped
            if (strobe_rise) begin
               next_state = ST_IDLE;
               if (!rw_q) begin
                  unique case (sel_q)
                     SEL_CONTROL: begin
                        next_ctrl = narrow_halfword_mode
                           ? merge_half(port_control, host_data_in[15:0], hw_upper)
                           : host_data_in;
                     end
                     SEL_ADDRESS: begin
                        next_wa = narrow_halfword_mode
                           ? merge_half(port_write_address, host_data_in[15:0], hw_upper)
                           : host_data_in;
                        next_ra = next_wa;
                     end
                     SEL_DATA_INC, SEL_DATA_FIXED: begin
                        if (narrow_halfword_mode && !hw_q) begin
                           next_wr_half_lo = host_data_in;
                        end else if (!req.wr_full) begin
                           req.wr_push = 1'b1;
                           req.wr_data = narrow_halfword_mode
                              ? (hw_first_low ? {host_data_in[15:0], wr_half_lo[15:0]}
                                              : {wr_half_lo[15:0], host_data_in[15:0]})
                              : host_data_in;
                           if (sel_q == SEL_DATA_INC) begin
                              next_wa = port_write_address + WORD_STEP;
                           end
                        end
                     end
                  endcase
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase
      // cpu side: data register has no cpu address
      if (cpu_sel && cpu_write) begin
         unique case (cpu_addr)
            ADDR_PORT_CONTROL: next_ctrl = cpu_wdata;
            ADDR_PORT_WRITE_ADDRESS: next_wa = cpu_wdata;
            ADDR_PORT_READ_ADDRESS: next_ra = cpu_wdata;
            ADDR_TRANSFER_REQUEST_CONTROL: next_trctl = cpu_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         strobe_q <= 1'b1;
         sel_q <= SEL_CONTROL;
         rw_q <= 1'b1;
         hw_q <= 1'b0;
         port_control <= RESET_PORT_CONTROL;
         port_write_address <= RESET_ADDRESS;
         port_read_address <= RESET_ADDRESS;
         transfer_request_control <= RESET_TRCTL;
         port_data <= '0;
         wr_half_lo <= '0;
      end else begin
         state <= next_state;
         strobe_q <= strobe_n;
         sel_q <= next_sel_q;
         rw_q <= next_rw_q;
         hw_q <= next_hw_q;
         port_control <= next_ctrl;
         port_write_address <= next_wa;
         port_read_address <= next_ra;
         transfer_request_control <= next_trctl;
         port_data <= next_data;
         wr_half_lo <= next_wr_half_lo;
      end
   end

   assign req.rd_addr = port_read_address;
   assign req.wr_addr = port_write_address;
   assign dma_rd_req = req.rd_req;
   assign dma_rd_addr = req.rd_addr;

   // ****************************************
   // host answer path
   // ****************************************
   // wait high while a fetch is pending or a write finds the buffer full
   assign wait_ready = (state == ST_FETCH)
                       | (strobe_fall && is_data && is_read && !second_half)
                       | ((state == ST_HOLD) && !rw_q && (sel_q != SEL_CONTROL)
                          && (sel_q != SEL_ADDRESS) && req.wr_full);

   // read data mux; fetched word shown as wait drops, second half from held word
   logic [31:0] rd_word;
   always_comb begin
      unique case (sel_q)
         SEL_CONTROL: rd_word = port_control;
         SEL_ADDRESS: rd_word = port_read_address;
         default: rd_word = next_data;
      endcase
   end

   logic [31:0] next_hdo;
   always_comb begin
      next_hdo = rd_word;
      if (narrow_halfword_mode) begin
         next_hdo = {16'h0000, (hw_upper ? rd_word[31:16] : rd_word[15:0])};
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         host_data_out <= '0;
         host_data_oe_n <= 1'b1;
      end else begin
         host_data_out <= next_hdo;
         host_data_oe_n <= ~(~strobe_n & rw_q & (state != ST_IDLE));
      end
   end

   // cpu read mux
   always_comb begin
      unique case (cpu_addr)
         ADDR_PORT_CONTROL: cpu_rdata = port_control;
         ADDR_PORT_WRITE_ADDRESS: cpu_rdata = port_write_address;
         ADDR_PORT_READ_ADDRESS: cpu_rdata = port_read_address;
         ADDR_TRANSFER_REQUEST_CONTROL: cpu_rdata = transfer_request_control;
         default: cpu_rdata = '0;
      endcase
   end

   // write buffer toward dma
   dma_write_buffer #(.DEPTH(WRITE_BUFFER_DEPTH)) u_wbuf (
      .mclk(mclk),
      .rst_n(rst_n),
      .req(req.engine),
      .out_valid(dma_wr_valid),
      .out_addr_data(dma_wr_addr_data),
      .out_ready(dma_wr_ready)
   );

   assign req.rd_done = dma_rd_done;
   assign req.rd_data = dma_rd_data;
endmodule : host_access_port

/* tb/host_access_port_properties.sv */
`timescale 1ns/1ps
// ****************************************
// host port checker
// ****************************************
module host_port_checker
   import host_port_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // host pins
   input wire logic port_chip_select_n,
   input wire logic data_strobe_a,
   input wire logic data_strobe_b,
   input wire logic [1:0] target_select,
   input wire logic read_write_select,
   input wire logic halfword_identifier,
   input wire logic narrow_halfword_mode,
   input wire logic host_data_oe_n,
   input wire logic wait_ready,
   // dma fetch
   input wire logic dma_rd_req,
   input wire logic dma_rd_done
);
   logic stb_n;
   logic data_rd;
   logic second;
   // combined strobe and read qualifiers
   assign stb_n = ~(data_strobe_a ^ data_strobe_b) | port_chip_select_n;
   assign data_rd = read_write_select && (target_select inside {SEL_DATA_INC, SEL_DATA_FIXED});
   assign second = narrow_halfword_mode && halfword_identifier;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   a_fetch_wait: assert property (
      $fell(stb_n) && data_rd && !second |-> ##[0:1] wait_ready) else $error("no wait at read");
   a_fetch_req: assert property (
      $fell(stb_n) && data_rd && !second |-> ##[0:2] dma_rd_req) else $error("no fetch at read");
   a_wait_hold: assert property (
      dma_rd_req && !dma_rd_done |-> wait_ready) else $error("wait low during fetch");
   a_fetch_end: assert property (
      dma_rd_done |=> !wait_ready && !host_data_oe_n) else $error("data not given after fetch");
   a_no_refetch: assert property (
      $fell(stb_n) && data_rd && second |-> !dma_rd_req [*4]) else $error("second half fetched");
   a_second_half: assert property (
      $fell(stb_n) && data_rd && second |-> ##[1:4] (!wait_ready && !host_data_oe_n))
      else $error("second half late");
   a_bus_release: assert property (
      $rose(stb_n) |=> host_data_oe_n) else $error("bus held after strobe");
   a_idle_quiet: assert property (
      stb_n [*3] |-> host_data_oe_n && !wait_ready) else $error("activity while idle");
   // main scenarios
   c_slow_read: cover property (dma_rd_req [*8]);
   c_second_half: cover property ($fell(stb_n) && data_rd && second);
   c_write_stall: cover property ($fell(stb_n) && !read_write_select ##1 wait_ready);
endmodule : host_port_checker

bind host_access_port host_port_checker chk (.mclk, .arst_n, .port_chip_select_n,
   .data_strobe_a, .data_strobe_b, .target_select, .read_write_select, .halfword_identifier,
   .narrow_halfword_mode, .host_data_oe_n, .wait_ready, .dma_rd_req, .dma_rd_done);

/* tb/dma_engine_model.sv */
`timescale 1ns/1ps
// ****************************************
// dma engine standing behind the port
// ****************************************
module dma_engine_model #(
   parameter logic [31:0] KEY = 32'h5a5a_a5a5
) (
   // clock
   input wire logic mclk,
   // read fetch
   input wire logic rd_req,
   input wire logic [31:0] rd_addr,
   output logic rd_done,
   output logic [31:0] rd_data,
   // write drain
   input wire logic wr_valid,
   input wire logic [63:0] wr_addr_data,
   output logic wr_ready,
   // pacing from the bench
   input wire logic hold_off,
   input wire logic slow
);
   logic [63:0] log [$];
   int fetches = 0;
   int wait_left = 0;
   logic req_seen = 1'b0;
   logic [31:0] addr_held = 32'h0;
   initial begin
      rd_done = 1'b0;
      rd_data = 32'h0;
   end
   // drain stalls while the bench holds it off
   assign wr_ready = ~hold_off;
   // fetch answered promptly or slowly; idle data toggles
   always @(posedge mclk) begin
      rd_done <= 1'b0;
      rd_data <= ~rd_data;
      req_seen <= rd_req;
      if (wr_valid && wr_ready) log.push_back(wr_addr_data);
      if (rd_req && !req_seen) begin
         fetches <= fetches + 1;
         wait_left <= slow ? 12 : 1;
         addr_held <= rd_addr;
      end else if (wait_left == 1) begin
         rd_done <= 1'b1;
         rd_data <= addr_held ^ KEY;
         wait_left <= 0;
      end else if (wait_left > 1) begin
         wait_left <= wait_left - 1;
      end
   end
endmodule : dma_engine_model

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
   import host_port_pkg::*;
   localparam logic [31:0] MEM_KEY = 32'h5a5a_a5a5;
   localparam logic [31:0] NPAT = 32'h0000_4000 ^ MEM_KEY;
   logic mclk, arst_n = 1'b0, cs_n = 1'b1, sa = 1'b1, sb = 1'b1, rw = 1'b0, hw = 1'b0;
   logic narrow = 1'b0, latch_n = 1'b1, cpu_sel = 1'b0, cpu_write = 1'b0, saw_wait = 1'b0;
   logic hold_off = 1'b0, slow = 1'b0, hoe_n, wait_ready, rd_req, rd_done, wr_valid, wr_ready;
   logic [1:0] tsel = 2'h0;
   logic [31:0] hdin = 32'h0, cpu_addr = 32'h0, cpu_wdata = 32'h0;
   logic [31:0] hdout, cpu_rdata, rd_addr, rd_data, got;
   logic [63:0] wr_ad;
   logic [31:0] regs [4] = '{ADDR_PORT_CONTROL, ADDR_PORT_WRITE_ADDRESS,
      ADDR_PORT_READ_ADDRESS, ADDR_TRANSFER_REQUEST_CONTROL};
   logic [31:0] rsts [4] = '{RESET_PORT_CONTROL, RESET_ADDRESS, RESET_ADDRESS, RESET_TRCTL};
   logic [31:0] vals [4] = '{32'h0000_0001, 32'h0000_1000, 32'h0000_2000, 32'h0000_0055};
   int bad_count = 0, total_checks = 0, cycles = 0, fetch_exp;
   host_access_port uut (.mclk(mclk), .arst_n(arst_n), .port_chip_select_n(cs_n),
      .data_strobe_a(sa), .data_strobe_b(sb), .address_latch_n(latch_n), .target_select(tsel),
      .read_write_select(rw), .halfword_identifier(hw), .narrow_halfword_mode(narrow),
      .host_data_in(hdin), .host_data_out(hdout), .host_data_oe_n(hoe_n),
      .wait_ready(wait_ready), .cpu_sel(cpu_sel), .cpu_write(cpu_write), .cpu_addr(cpu_addr),
      .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .dma_rd_req(rd_req), .dma_rd_addr(rd_addr),
      .dma_rd_done(rd_done), .dma_rd_data(rd_data), .dma_wr_valid(wr_valid),
      .dma_wr_addr_data(wr_ad), .dma_wr_ready(wr_ready));
   dma_engine_model #(.KEY(MEM_KEY)) partner (.mclk(mclk), .rd_req(rd_req), .rd_addr(rd_addr),
      .rd_done(rd_done), .rd_data(rd_data), .wr_valid(wr_valid), .wr_addr_data(wr_ad),
      .wr_ready(wr_ready), .hold_off(hold_off), .slow(slow));
   // clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic cpu_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      cpu_sel <= 1'b1;
      cpu_write <= 1'b1;
      cpu_addr <= a;
      cpu_wdata <= d;
      @(posedge mclk);
      cpu_sel <= 1'b0;
      cpu_write <= 1'b0;
   endtask : cpu_wr
   task automatic cpu_rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge mclk);
      cpu_sel <= 1'b1;
      cpu_addr <= a;
      @(negedge mclk);
      d = cpu_rdata;
      @(posedge mclk);
      cpu_sel <= 1'b0;
   endtask : cpu_rd
   // one host access; equal strobes are idle, lvl picks which strobe moves and latch use
   task automatic host(input logic [1:0] sel, input logic rd, input logic half,
                       input logic lvl, input logic [31:0] wd, output logic [31:0] d);
      int n;
      @(posedge mclk);
      tsel <= sel;
      rw <= rd;
      hw <= half;
      hdin <= wd;
      latch_n <= ~lvl;
      @(posedge mclk);
      sa <= lvl;
      sb <= ~lvl;
      @(posedge mclk);
      latch_n <= 1'b1;
      for (n = 2; n < 400; n++) begin
         @(negedge mclk);
         if (wait_ready === 1'b1) saw_wait = 1'b1;
         if (n >= 4 && wait_ready === 1'b0) break;
      end
      if (n == 400) chk("ready", 32'h0, 32'h1);
      d = hdout;
      @(posedge mclk);
      sa <= 1'b1;
      sb <= 1'b1;
      repeat (4) @(posedge mclk);
   endtask : host
   initial begin
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      cs_n <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         cpu_rd(regs[i], got);
         chk("reset value", rsts[i], got);
      end
      cpu_rd(32'h0188_000c, got);
      chk("unmapped", 32'h0, got);
      for (int i = 0; i < 4; i++) cpu_wr(regs[i], vals[i]);
      for (int i = 0; i < 4; i++) begin
         cpu_rd(regs[i], got);
         chk("cpu register", vals[i], got);
      end
      host(SEL_CONTROL, 1'b1, 1'b0, 1'b0, 32'h0, got);
      chk("host control", vals[0], got);
      host(SEL_ADDRESS, 1'b0, 1'b0, 1'b1, 32'h0000_3000, got);
      cs_n <= 1'b1;
      host(SEL_ADDRESS, 1'b0, 1'b0, 1'b0, 32'h0000_7000, got);
      cs_n <= 1'b0;
      for (int i = 1; i < 3; i++) begin
         cpu_rd(regs[i], got);
         chk("address copy", 32'h0000_3000, got);
      end
      // four writes with room, five with the drain stalled
      saw_wait = 1'b0;
      for (int k = 0; k < 4; k++)
         host(k < 2 ? SEL_DATA_INC : SEL_DATA_FIXED, 1'b0, 1'b0, 1'b0, 32'hc0de_0000 + k, got);
      chk("wait with room", 32'h0, {31'h0, saw_wait});
      hold_off <= 1'b1;
      fork
         for (int k = 4; k < 9; k++)
            host(SEL_DATA_FIXED, 1'b0, 1'b0, 1'b0, 32'hc0de_0000 + k, got);
         begin
            repeat (100) @(posedge mclk);
            hold_off <= 1'b0;
         end
      join
      chk("wait when full", 32'h1, {31'h0, saw_wait});
      repeat (20) @(posedge mclk);
      chk("drained", 32'd9, partner.log.size());
      for (int k = 0; k < 9; k++) begin
         chk("drain address", 32'h0000_3000 + 4 * (k < 3 ? k : 2), partner.log[k][63:32]);
         chk("drain data", 32'hc0de_0000 + k, partner.log[k][31:0]);
      end
      // slow, prompt and incremented reads
      slow <= 1'b1;
      host(SEL_DATA_FIXED, 1'b1, 1'b0, 1'b0, 32'h0, got);
      chk("slow read", 32'h0000_3000 ^ MEM_KEY, got);
      slow <= 1'b0;
      host(SEL_DATA_INC, 1'b1, 1'b0, 1'b0, 32'h0, got);
      chk("prompt read", 32'h0000_3000 ^ MEM_KEY, got);
      host(SEL_DATA_FIXED, 1'b1, 1'b0, 1'b0, 32'h0, got);
      chk("next read", 32'h0000_3004 ^ MEM_KEY, got);
      // narrow reads in both half orders
      narrow <= 1'b1;
      cpu_wr(ADDR_PORT_READ_ADDRESS, 32'h0000_4000);
      for (int ord = 1; ord >= 0; ord--) begin
         cpu_wr(ADDR_PORT_CONTROL, 32'(ord));
         fetch_exp = partner.fetches + 1;
         host(SEL_DATA_FIXED, 1'b1, 1'b0, 1'b1, 32'h0, got);
         chk("first half", ord != 0 ? NPAT[15:0] : NPAT[31:16], {16'h0, got[15:0]});
         host(SEL_DATA_FIXED, 1'b1, 1'b1, 1'b1, 32'h0, got);
         chk("second half", ord != 0 ? NPAT[31:16] : NPAT[15:0], {16'h0, got[15:0]});
         chk("fetches", fetch_exp, partner.fetches);
      end
      report_and_stop();
   end
endmodule : tb
